// >>> hdl/dswi_top.sv
// dual serial wiper interface: shift mode and two-wire slave mode
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - select pin low shift mode, high two-wire
// - shift word eight bits msb first
// - strobe low shifts input each clock rise
// - strobe rise copies shift register to wiper
// - excess bits keep last eight only
// - shifted-out bits leave on open-drain chain output
// - two chained: first byte goes downstream
// - address upper six fixed, lsb from strap
// - ack on match, stay off bus otherwise
// - direction bit high read, low write
// - instruction byte follows address in write
// - midscale command overwrites wiper with midscale
// - shutdown keeps register, still accepts writes
// - data byte after instruction loads wiper
// - data changes only while clock low
// - read returns wiper right after address ack
// - device detects start and stop conditions
// - further write bytes update under same instruction
// - further read bytes return wiper again
// - midscale code is 80 hex
// - reset presets wiper to midscale
////////////////////////////////////////////////////////////////////////////////
module dswi_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic interface_select,
  input wire logic serial_clk,
  input wire logic shift_in,
  input wire logic load_strobe_n,
  input wire logic addr_strap_bit,
  output logic chain_out_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] wiper_register,
  output logic shutdown,
  output logic term_a_open
);
  typedef struct packed {
    logic [2:0] clk_s;
    logic [2:0] dat_s;
    logic [2:0] ld_s;
    logic [2:0] sel_s;
    logic [2:0] strap_s;
    logic clk_q;
    logic dat_q;
    logic ld_q;
    logic sel_q;
    logic strap_q;
    logic [7:0] shreg;
    logic chain_oe;
    logic [7:0] wiper;
    logic sd;
    logic midscale_mode;
    dswi_pkg::dswi_tw_e tw;
    logic [3:0] bitcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic is_read;
    logic host_nack;
    logic sda_o;
    logic sda_en;
  } dswi_state_s;

  dswi_state_s st;
  dswi_state_s next_st;
  logic clk_rise;
  logic clk_fall;
  logic ld_rise;
  logic start_c;
  logic stop_c;
  logic tw_active;
  logic addr_hit;
  logic [3:0] ack_end;

  // a change counts only once stages two and three agree
  always_comb begin
    clk_rise = (st.clk_s[2] == st.clk_s[1]) && st.clk_s[1] && !st.clk_q;
    clk_fall = (st.clk_s[2] == st.clk_s[1]) && !st.clk_s[1] && st.clk_q;
    ld_rise = (st.ld_s[2] == st.ld_s[1]) && st.ld_s[1] && !st.ld_q;
    start_c = st.sel_q && st.clk_q && (st.dat_s[2] == st.dat_s[1]) && !st.dat_s[1] && st.dat_q;
    stop_c = st.sel_q && st.clk_q && (st.dat_s[2] == st.dat_s[1]) && st.dat_s[1] && !st.dat_q;

    // idle and ignore states never touch the bus
    tw_active = (st.tw != dswi_pkg::TW_IDLE) && (st.tw != dswi_pkg::TW_IGNORE);

    // byte is address plus direction: top seven bits are the address
    addr_hit = (st.rx[7:2] == dswi_pkg::ADDR_UPPER) && (st.rx[1] == st.strap_q);

    // bit count after the rising edge of the acknowledge clock
    ack_end = dswi_pkg::BIT_ACK + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.clk_s = {st.clk_s[1:0], serial_clk};
    next_st.dat_s = {st.dat_s[1:0], shift_in};
    next_st.ld_s = {st.ld_s[1:0], load_strobe_n};
    next_st.sel_s = {st.sel_s[1:0], interface_select};
    next_st.strap_s = {st.strap_s[1:0], addr_strap_bit};
    if (st.clk_s[2] == st.clk_s[1]) begin
      next_st.clk_q = st.clk_s[1];
    end

    if (st.dat_s[2] == st.dat_s[1]) begin
      next_st.dat_q = st.dat_s[1];
    end

    if (st.ld_s[2] == st.ld_s[1]) begin
      next_st.ld_q = st.ld_s[1];
    end

    if (st.sel_s[2] == st.sel_s[1]) begin
      next_st.sel_q = st.sel_s[1];
    end

    if (st.strap_s[2] == st.strap_s[1]) begin
      next_st.strap_q = st.strap_s[1];
    end

    // open-drain data line: only ever pulled low
    next_st.sda_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    if (!st.sel_q) begin
      // shift mode: no two-wire activity
      next_st.tw = dswi_pkg::TW_IDLE;
      next_st.sda_en = 1'b0;
      next_st.bitcnt = 4'h0;

      if (clk_rise && !st.ld_q) begin
        next_st.shreg = {st.shreg[6:0], st.dat_q};
        next_st.chain_oe = !st.shreg[7];
      end

      if (ld_rise) begin
        next_st.wiper = st.shreg;
      end
    end else begin
      // chain output released in two-wire mode
      next_st.chain_oe = 1'b0;

      //////////////////////////////////////////////////////////////////////////
      // rising clock: sample the line and count bits
      if (clk_rise && tw_active) begin
        if (st.bitcnt < dswi_pkg::BIT_ACK) begin
          next_st.rx = {st.rx[6:0], st.dat_q};
          next_st.bitcnt = st.bitcnt + 4'h1;
        end else if (st.bitcnt == dswi_pkg::BIT_ACK) begin
          // ninth bit: host level kept for the read path
          next_st.host_nack = st.dat_q;
          next_st.bitcnt = ack_end;
        end else begin
          next_st.bitcnt = st.bitcnt;
        end
      end

      //////////////////////////////////////////////////////////////////////////
      // falling clock: outputs move only while the clock is low
      if (clk_fall && tw_active) begin
        if (st.bitcnt < dswi_pkg::BIT_ACK) begin
          // the fall right after a start finds a zero count and does nothing
          if (st.tw == dswi_pkg::TW_READ && st.bitcnt != 4'h0) begin
            next_st.tx = {st.tx[6:0], 1'b0};
            next_st.sda_en = !st.tx[6];
          end
        end else if (st.bitcnt == dswi_pkg::BIT_ACK) begin
          // eight bits in: start of the acknowledge clock
          next_st.sda_en = 1'b0;
          case (st.tw)
            dswi_pkg::TW_ADDR: begin
              if (addr_hit) begin
                next_st.sda_en = 1'b1;
                next_st.is_read = st.rx[0];
              end else begin
                next_st.tw = dswi_pkg::TW_IGNORE;
              end
            end

            dswi_pkg::TW_INSTR: begin
              next_st.sda_en = 1'b1;
              // msb and five low bits are don't care
              next_st.midscale_mode = st.rx[dswi_pkg::INSTR_MIDSCALE_BIT];
              next_st.sd = st.rx[dswi_pkg::INSTR_SHUTDOWN_BIT];
              if (st.rx[dswi_pkg::INSTR_MIDSCALE_BIT]) begin
                next_st.wiper = dswi_pkg::MIDSCALE_CODE;
              end
            end

            dswi_pkg::TW_DATA: begin
              next_st.sda_en = 1'b1;
              // midscale command holds the wiper at midscale
              if (st.midscale_mode) begin
                next_st.wiper = dswi_pkg::MIDSCALE_CODE;
              end else begin
                next_st.wiper = st.rx;
              end
            end

            dswi_pkg::TW_READ: begin
              // host owns the acknowledge bit of a read
              next_st.sda_en = 1'b0;
            end

            default: begin
              next_st.sda_en = 1'b0;
            end
          endcase
        end else begin
          // end of the acknowledge clock
          next_st.sda_en = 1'b0;
          next_st.bitcnt = 4'h0;
          case (st.tw)
            dswi_pkg::TW_ADDR: begin
              if (st.is_read) begin
                next_st.tw = dswi_pkg::TW_READ;
              end else begin
                next_st.tw = dswi_pkg::TW_INSTR;
              end
            end

            dswi_pkg::TW_INSTR: begin
              next_st.tw = dswi_pkg::TW_DATA;
            end

            dswi_pkg::TW_READ: begin
              // host nack ends the read; drive nothing until the next start or stop
              if (st.host_nack) begin
                next_st.tw = dswi_pkg::TW_IGNORE;
              end
            end

            default: begin
              // instruction stays for every further data byte
              next_st.tw = st.tw;
            end
          endcase

          if (next_st.tw == dswi_pkg::TW_READ) begin
            next_st.tx = st.wiper;
            next_st.sda_en = !st.wiper[7];
          end
        end
      end

      //////////////////////////////////////////////////////////////////////////
      // start and stop win over any bit activity in the same cycle
      if (start_c) begin
        next_st.tw = dswi_pkg::TW_ADDR;
        next_st.bitcnt = 4'h0;
        next_st.is_read = 1'b0;
        next_st.host_nack = 1'b0;
        next_st.sda_en = 1'b0;
      end else if (stop_c) begin
        next_st.tw = dswi_pkg::TW_IDLE;
        next_st.bitcnt = 4'h0;
        next_st.sda_en = 1'b0;
      end
    end
  end

  // strobe and clock both need edges, so all inputs pass the same filter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.clk_s <= 3'h0;
      st.ld_s <= 3'h7;
      st.ld_q <= 1'b1;
      st.dat_s <= 3'h7;
      st.dat_q <= 1'b1;
      st.wiper <= dswi_pkg::MIDSCALE_CODE;
      st.tw <= dswi_pkg::TW_IDLE;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    chain_out_oe = st.chain_oe;
    sda_out = st.sda_o;
    sda_oe = st.sda_en;
    wiper_register = st.wiper;
    shutdown = st.sd;
    term_a_open = st.sd;
  end
endmodule : dswi_top

// >>> hdl/dswi_pkg.sv
// constants and types for the dual serial wiper interface
package dswi_pkg;
  localparam int WIPER_W = 8;
  localparam logic [7:0] MIDSCALE_CODE = 8'h80;
  localparam logic [5:0] ADDR_UPPER = 6'h16;
  localparam int INSTR_MIDSCALE_BIT = 6;
  localparam int INSTR_SHUTDOWN_BIT = 5;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int SYNC_W = 3;

  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_INSTR = 3'b010,
    TW_DATA = 3'b011,
    TW_READ = 3'b100,
    TW_IGNORE = 3'b101
  } dswi_tw_e;
endpackage : dswi_pkg

// >>> tb/dswi_host.sv
// host serial master model for both modes
`timescale 1ns/1ps
module dswi_host (
  input wire logic clk,
  input wire logic line,
  output logic scl,
  output logic d,
  output logic cs_n
);
  logic [15:0] r;
  initial begin
    scl = 1'h0;
    d = 1'h1;
    cs_n = 1'h1;
    r = 16'h0000;
  end
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // slow bits leave room for the pulled-up chain node
  task bitx(input logic b);
    tick(4);
    d = b;
    tick(4);
    scl = 1'h1;
    tick(8);
    r = {r[14:0], line};
    scl = 1'h0;
  endtask : bitx
  task xfer(input logic [7:0] v, input logic a);
    for (int i = 7; i >= 0; i--) bitx(v[i]);
    bitx(a);
  endtask : xfer
  task shift(input logic [15:0] v, input int n);
    cs_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) bitx(v[i]);
    tick(4);
    cs_n = 1'h1;
    tick(16);
  endtask : shift
  task cond(input logic b);
    tick(4);
    d = b;
    tick(4);
    scl = 1'h1;
    tick(8);
    d = ~b;
    tick(8);
    scl = ~b;
  endtask : cond
endmodule : dswi_host

// >>> tb/dswi_top_sva.sv
// port assertions for the wiper interface
`timescale 1ns/1ps
module dswi_top_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic interface_select,
  input wire logic serial_clk,
  input wire logic load_strobe_n,
  input wire logic chain_out_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [7:0] wiper_register,
  input wire logic shutdown,
  input wire logic term_a_open
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_shift; !interface_select [*5]; endsequence
  sequence s_low; (!interface_select && !load_strobe_n) [*8]; endsequence
  a_reset_mid: assert property ($fell(rst) |-> wiper_register == 8'h80) else $error("preset");
  a_shift_quiet: assert property (s_shift |-> !sda_oe) else $error("sda in shift");
  a_chain_off: assert property (interface_select [*8] |-> !chain_out_oe) else $error("chain");
  a_shift_noshut: assert property (s_shift |=> $stable(shutdown)) else $error("shutdown");
  a_hold_low: assert property (s_low |-> $stable(wiper_register)) else $error("early load");
  a_load_rise: assert property (!interface_select && $changed(wiper_register) |-> load_strobe_n) else $error("load");
  a_ack_low: assert property (sda_oe |-> !sda_out) else $error("sda level");
  a_sda_change: assert property ($changed(sda_oe) |-> !serial_clk) else $error("sda edge");
  a_shut_open: assert property (shutdown == term_a_open) else $error("term a");
endmodule : dswi_top_sva
bind dswi_top dswi_top_sva u_sva (.sys_clk, .rst, .interface_select, .serial_clk, .load_strobe_n,
  .chain_out_oe, .sda_out, .sda_oe, .wiper_register, .shutdown, .term_a_open);

// >>> tb/dswi_top_test.sv
// self-checking bench for the wiper interface
`timescale 1ns/1ps
module dswi_top_test;
  logic sys_clk, rst, sel, strap, scl, d, cs_n, chain_oe, sda_out, sda_oe, shut, a_open;
  logic [7:0] wiper;
  int failures, tests_run;
  dswi_top DUT (.sys_clk(sys_clk), .rst(rst), .interface_select(sel), .serial_clk(scl), .shift_in(d & ~sda_oe),
    .load_strobe_n(cs_n), .addr_strap_bit(strap), .chain_out_oe(chain_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .wiper_register(wiper), .shutdown(shut), .term_a_open(a_open));
  dswi_host host (.clk(sys_clk), .line(sel ? (d & ~sda_oe) : ~chain_oe), .scl(scl), .d(d), .cs_n(cs_n));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_of_test;
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task wr(input logic a, input logic [7:0] ins, input logic [7:0] v, input logic [7:0] exp);
    host.cond(1'h1);
    host.xfer({6'h16, a, 1'h0}, 1'h1);
    chk({7'h00, host.r[0]}, {7'h00, a != strap});
    host.xfer(ins, 1'h1);
    host.xfer(~v, 1'h1);
    host.xfer(v, 1'h1);
    host.cond(1'h0);
    chk(wiper, exp);
  endtask : wr
  task rd(input logic [7:0] exp);
    host.cond(1'h1);
    host.xfer({6'h16, strap, 1'h1}, 1'h1);
    host.xfer(8'hFF, 1'h0);
    chk(host.r[8:1], exp);
    host.xfer(8'hFF, 1'h1);
    chk(host.r[8:1], exp);
    host.cond(1'h0);
  endtask : rd
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    rst = 1'h1;
    sel = 1'h0;
    strap = 1'h1;
    repeat (4) @(negedge sys_clk);
    rst = 1'h0;
    chk(wiper, 8'h80);
    host.tick(8);
    host.shift(16'h00A5, 8);
    chk(wiper, 8'hA5);
    host.shift(16'h3C96, 16);
    chk(wiper, 8'h96);
    chk(host.r[7:0], 8'h3C);
    sel = 1'h1;
    host.tick(8);
    wr(1'h0, 8'h9F, 8'h5A, 8'h96);
    wr(1'h1, 8'h9F, 8'h5A, 8'h5A);
    wr(1'h1, 8'h20, 8'h11, 8'h11);
    chk({7'h00, shut & a_open}, 8'h01);
    rd(8'h11);
    wr(1'h1, 8'h40, 8'h22, 8'h80);
    chk({7'h00, shut | a_open}, 8'h00);
    rd(8'h80);
    strap = 1'h0;
    host.tick(8);
    wr(1'h0, 8'h1F, 8'h33, 8'h33);
    rd(8'h33);
    end_of_test();
  end
endmodule : dswi_top_test
